// ===== rtl/tmfc_pkg.sv
// Constants, carriers and state layout for the thermal and feature
// control register bank.
// Assumes a core-side register port with word-wide data and an address
// equal to the register number.
package tmfc_pkg;

	// ==========================================================
	// Widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 64;
	localparam int TGT_W  = 16;

	// ==========================================================
	// Register numbers, used directly as port addresses
	localparam logic [ADDR_W-1:0] OFS_EVTSEL0  = 16'h0186;
	localparam logic [ADDR_W-1:0] OFS_EVTSEL1  = 16'h0187;
	localparam logic [ADDR_W-1:0] OFS_OPSTAT   = 16'h0198;
	localparam logic [ADDR_W-1:0] OFS_OPCTL    = 16'h0199;
	localparam logic [ADDR_W-1:0] OFS_CLKMOD   = 16'h019A;
	localparam logic [ADDR_W-1:0] OFS_THIRQ    = 16'h019B;
	localparam logic [ADDR_W-1:0] OFS_THSTAT   = 16'h019C;
	localparam logic [ADDR_W-1:0] OFS_THERM2   = 16'h019D;
	localparam logic [ADDR_W-1:0] OFS_FEAT     = 16'h01A0;

	// ==========================================================
	// Field positions
	localparam int TGT_LSB      = 0;
	localparam int TM_SEL_BIT   = 16;
	localparam int ATC_EN_BIT   = 3;
	localparam int PERF_MON_BIT = 7;
	localparam int FLOAT_ERROR_PIN_MUX_BIT = 10;
	localparam int BTS_UNAV_BIT = 11;
	localparam int TM2_EN_BIT   = 13;

	// Bits of the feature-enable word that read back as non-zero
	localparam logic [DATA_W-1:0] FE_READ_MASK = 64'h0000_0000_0000_2C88;

	// ==========================================================
	// Reset values
	localparam logic [DATA_W-1:0] RST_WORD   = 64'h0000_0000_0000_0000;
	localparam logic [TGT_W-1:0]  RST_TARGET = 16'h0000;
	localparam logic              RST_TM_SEL = 1'b0;
	localparam logic              RST_ATC_EN = 1'b0;
	localparam logic              RST_FLOAT_ERROR_PIN   = 1'b0;
	localparam logic              RST_TM2_EN = 1'b0;

	// ==========================================================
	// Register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} tmfc_req_s;

	// ==========================================================
	// Whole state of the bank
	typedef struct packed {
		logic [DATA_W-1:0] evtsel0;
		logic [DATA_W-1:0] evtsel1;
		logic [DATA_W-1:0] op_ctl;
		logic [DATA_W-1:0] clk_mod;
		logic [DATA_W-1:0] therm_irq;
		logic [DATA_W-1:0] therm_stat;
		logic [TGT_W-1:0]  target;
		logic              tm_sel;
		logic              atc_en;
		logic              float_error_pin_mux;
		logic              tm2_en;
		logic              duty_act;
		logic              freq_act;
		logic [TGT_W-1:0]  op_target;
		logic              float_error_pin_pin;
		logic [DATA_W-1:0] rdata;
	} tmfc_state_s;

endpackage

// ===== rtl/tmfc_sync.sv
// Two-stage synchroniser for levels arriving from outside the core
// clock domain.
// Assumes the inputs are slow levels; pulses shorter than one clock
// period may be missed.
`timescale 1ns/10ps

module tmfc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             resetn_i,
	// Asynchronous level in, synchronised level out
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} tmfc_sync_state_s;

	tmfc_sync_state_s st_reg;
	tmfc_sync_state_s st_next;

	// ==========================================================
	// Only the second stage is ever looked at
	always_comb begin
		st_next        = st_reg;
		st_next.meta   = async_i;
		st_next.stable = st_reg.meta;
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_o = st_reg.stable;

endmodule

// ===== rtl/tmfc_top.sv
// Thermal mode, thermal control enables, float error pin multiplexing
// and feature-availability flags of one processor core.
// Assumes a register port with one-cycle strobes and read data in the
// following cycle; the thermal sensor level arrives asynchronously.
//
// How it works
// [R1] Mode select bit 16: duty-cycle or frequency
// [R2] Enable bit 3 clear disables both mechanisms
// [R3] Enable bit 3 is software read/write
// [R4] Mux bit set: pin shows pending break
// [R5] Mux bit clear: pin keeps legacy behaviour
// [R6] Software sets mux bit before extended interrupts
// [R7] Frequency mode engages on enable and hot
// [R8] Engaged mode applies last written target
// [R9] Bit 7 reads performance monitoring available
// [R10] Bit 11 reads branch trace unavailable
// [R11] Reserved bits read zero, writes ignored
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps

module tmfc_top
	import tmfc_pkg::*;
#(
	parameter logic PERF_MON_AVAIL = 1'b1,
	parameter logic BTS_UNAVAIL    = 1'b1
) (
	// Clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              resetn_i,
	// Register port
	input  wire tmfc_req_s         reg_req_i,
	output logic      [DATA_W-1:0] rd_data_o,
	// Thermal sensor threshold pin
	input  wire logic              therm_hot_i,
	// Error sources from the core
	input  wire logic              fp_error_i,
	input  wire logic              break_event_i,
	// Thermal control and error pin outputs
	output logic                   duty_mod_active_o,
	output logic                   freq_trans_active_o,
	output logic      [TGT_W-1:0]  op_target_o,
	output logic                   float_error_pin_o
);

	tmfc_state_s st_reg;
	tmfc_state_s st_next;
	logic        hot;

	// ==========================================================
	// Thermal sensor crossing
	// The sensor is a pin, so it passes two flops before any use
	tmfc_sync #(
		.WIDTH (1)
	) u_hot_sync (
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.async_i    (therm_hot_i),
		.sync_o     (hot)
	);

	// ==========================================================
	// Read value builders
	// Secondary thermal control: target field and mode select only
	function automatic logic [DATA_W-1:0] therm2_word(
		input tmfc_state_s s
	);
		logic [DATA_W-1:0] w;
		w = '0;
		w[TGT_LSB +: TGT_W] = s.target;
		w[TM_SEL_BIT]       = s.tm_sel;
		return w;
	endfunction

	// Feature enable: three stored enables and two fixed flags
	function automatic logic [DATA_W-1:0] feat_word(
		input tmfc_state_s s
	);
		logic [DATA_W-1:0] w;
		w = '0;
		w[ATC_EN_BIT]   = s.atc_en;
		w[PERF_MON_BIT] = PERF_MON_AVAIL;
		w[FLOAT_ERROR_PIN_MUX_BIT] = s.float_error_pin_mux;
		w[BTS_UNAV_BIT] = BTS_UNAVAIL;
		w[TM2_EN_BIT]   = s.tm2_en;
		return w;
	endfunction

	// Operating point status shows the point that is being applied
	function automatic logic [DATA_W-1:0] opstat_word(
		input tmfc_state_s s
	);
		logic [DATA_W-1:0] w;
		w = '0;
		w[TGT_LSB +: TGT_W] = s.op_target;
		return w;
	endfunction

	// ==========================================================
	// Next-state logic
	always_comb begin
		st_next = st_reg;

		// Register writes; unmapped addresses are dropped
		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				OFS_EVTSEL0: begin
					st_next.evtsel0 = reg_req_i.wdata;
				end
				OFS_EVTSEL1: begin
					st_next.evtsel1 = reg_req_i.wdata;
				end
				OFS_OPCTL: begin
					st_next.op_ctl = reg_req_i.wdata;
				end
				OFS_CLKMOD: begin
					st_next.clk_mod = reg_req_i.wdata;
				end
				OFS_THIRQ: begin
					st_next.therm_irq = reg_req_i.wdata;
				end
				OFS_THSTAT: begin
					st_next.therm_stat = reg_req_i.wdata;
				end
				OFS_THERM2: begin
					// Only target and mode select are stored
					st_next.target = reg_req_i.wdata[TGT_LSB +: TGT_W]; // see [R8]
					st_next.tm_sel = reg_req_i.wdata[TM_SEL_BIT]; // see [R1]
				end
				OFS_FEAT: begin
					// Flag bits and reserved bits are not stored
					st_next.atc_en   = reg_req_i.wdata[ATC_EN_BIT]; // see [R3]
					st_next.float_error_pin_mux = reg_req_i.wdata[FLOAT_ERROR_PIN_MUX_BIT];
					st_next.tm2_en   = reg_req_i.wdata[TM2_EN_BIT];
				end
				default: begin
				end
			endcase
		end

		// Read data stand for exactly one cycle, zero otherwise
		st_next.rdata = '0;
		if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				OFS_EVTSEL0: st_next.rdata = st_reg.evtsel0;
				OFS_EVTSEL1: st_next.rdata = st_reg.evtsel1;
				OFS_OPSTAT:  st_next.rdata = opstat_word(st_reg);
				OFS_OPCTL:   st_next.rdata = st_reg.op_ctl;
				OFS_CLKMOD:  st_next.rdata = st_reg.clk_mod;
				OFS_THIRQ:   st_next.rdata = st_reg.therm_irq;
				OFS_THSTAT:  st_next.rdata = st_reg.therm_stat;
				OFS_THERM2:  st_next.rdata = therm2_word(st_reg); // see [R11]
				OFS_FEAT:    st_next.rdata = feat_word(st_reg); // see [R9]
				default:     st_next.rdata = '0;
			endcase
		end

		// Automatic thermal control: master enable gates both modes
		st_next.duty_act = st_reg.atc_en & ~st_reg.tm_sel & hot; // see [R2]
		// Frequency mode also needs its own enable and a hot die
		st_next.freq_act = st_reg.atc_en & st_reg.tm_sel
			& st_reg.tm2_en & hot; // see [R7]

		// Target is applied only while frequency mode is engaged
		if (st_next.freq_act) begin
			st_next.op_target = st_reg.target; // see [R8]
		end else begin
			st_next.op_target = RST_TARGET;
		end

		// Error pin source select; the core owns both sources
		if (st_reg.float_error_pin_mux) begin
			st_next.float_error_pin_pin = break_event_i; // see [R4]
		end else begin
			st_next.float_error_pin_pin = fp_error_i; // see [R5]
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg.evtsel0    <= RST_WORD;
			st_reg.evtsel1    <= RST_WORD;
			st_reg.op_ctl     <= RST_WORD;
			st_reg.clk_mod    <= RST_WORD;
			st_reg.therm_irq  <= RST_WORD;
			st_reg.therm_stat <= RST_WORD;
			st_reg.target     <= RST_TARGET;
			st_reg.tm_sel     <= RST_TM_SEL;
			st_reg.atc_en     <= RST_ATC_EN;
			st_reg.float_error_pin_mux   <= RST_FLOAT_ERROR_PIN;
			st_reg.tm2_en     <= RST_TM2_EN;
			st_reg.duty_act   <= 1'b0;
			st_reg.freq_act   <= 1'b0;
			st_reg.op_target  <= RST_TARGET;
			st_reg.float_error_pin_pin   <= 1'b0;
			st_reg.rdata      <= RST_WORD;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Outputs, all straight from flops
	assign rd_data_o           = st_reg.rdata;
	assign duty_mod_active_o   = st_reg.duty_act;
	assign freq_trans_active_o = st_reg.freq_act;
	assign op_target_o         = st_reg.op_target;
	assign float_error_pin_o   = st_reg.float_error_pin_pin;

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	// Read of the feature word
	logic rd_feat;
	assign rd_feat = reg_req_i.rd && (reg_req_i.addr == OFS_FEAT);

	// Mode select picks at most one mechanism
	mode_select_a: assert property ( // see [R1]
		st_reg.atc_en && hot |=>
			(duty_mod_active_o == !$past(st_reg.tm_sel))
			&& !(duty_mod_active_o && freq_trans_active_o))
		else $error("thermal mode select not followed");

	// Master enable clear blocks both for as long as it stays clear
	master_off_a: assert property ( // see [R2]
		!st_reg.atc_en [*2] |=>
			!duty_mod_active_o && !freq_trans_active_o)
		else $error("thermal mechanism active while disabled");

	// Enable bit written is read back two cycles later
	enable_rw_a: assert property ( // see [R3]
		reg_req_i.wr && reg_req_i.addr == OFS_FEAT ##1 rd_feat |=>
			rd_data_o[ATC_EN_BIT] == $past(reg_req_i.wdata[ATC_EN_BIT], 2))
		else $error("thermal enable bit did not read back");

	// Multiplexed pin follows the break event one cycle later
	pin_break_a: assert property ( // see [R4]
		st_reg.float_error_pin_mux |=> float_error_pin_o == $past(break_event_i))
		else $error("error pin not showing break event");

	// Legacy pin follows the floating point error
	pin_legacy_a: assert property ( // see [R5]
		!st_reg.float_error_pin_mux |=> float_error_pin_o == $past(fp_error_i))
		else $error("error pin not showing legacy error");

	// Frequency mode engages one cycle after all its causes
	freq_engage_a: assert property ( // see [R7]
		st_reg.atc_en && st_reg.tm_sel && st_reg.tm2_en && hot
			|=> freq_trans_active_o)
		else $error("frequency mode did not engage");

	// Frequency mode never active without its own enable
	freq_gate_a: assert property ( // see [R7]
		freq_trans_active_o |-> $past(st_reg.tm2_en) && $past(hot))
		else $error("frequency mode active without cause");

	// Applied target is the last written target
	target_apply_a: assert property ( // see [R8]
		freq_trans_active_o |-> op_target_o == $past(st_reg.target))
		else $error("applied target differs from written one");

	// Fixed flags read as the build options
	flags_read_a: assert property ( // see [R9]
		rd_feat |=> rd_data_o[PERF_MON_BIT] == PERF_MON_AVAIL
			&& rd_data_o[BTS_UNAV_BIT] == BTS_UNAVAIL) // see [R10]
		else $error("availability flags read wrong");

	// Reserved feature bits always read zero
	reserved_zero_a: assert property ( // see [R11]
		rd_feat |=> (rd_data_o & ~FE_READ_MASK) == '0)
		else $error("reserved feature bits not zero");

	// Read data are zero in any cycle not after a read
	rdata_idle_a: assert property ( // see [R11]
		!reg_req_i.rd |=> rd_data_o == '0)
		else $error("read data outside read cycle");

endmodule

// ===== testbench/tmfc_top_bench.sv
// Self-checking bench for the thermal and feature control register bank.
// Assumes the register port, thermal level and error sources are all
// driven here on the core clock; no far-side model is needed.
`timescale 1ns/10ps

module tmfc_top_bench;
	import tmfc_pkg::*;

	// ==========================================================
	// Stimulus and observation signals
	logic              core_clk_i;
	logic              resetn_i;
	tmfc_req_s         req;
	logic [DATA_W-1:0] rd_data_o;
	logic              therm_hot_i;
	logic              fp_error_i;
	logic              break_event_i;
	logic              duty_o;
	logic              freq_o;
	logic [TGT_W-1:0]  tgt_o;
	logic              pin_o;
	logic [DATA_W-1:0] exp_q[$];
	logic              rd_seen;
	int                n_mismatch;
	int                check_count;
	int                cyc;

	tmfc_top #(
		.PERF_MON_AVAIL (1'b1),
		.BTS_UNAVAIL    (1'b1)
	) tmfc_top_i (
		.core_clk_i          (core_clk_i),
		.resetn_i            (resetn_i),
		.reg_req_i           (req),
		.rd_data_o           (rd_data_o),
		.therm_hot_i         (therm_hot_i),
		.fp_error_i          (fp_error_i),
		.break_event_i       (break_event_i),
		.duty_mod_active_o   (duty_o),
		.freq_trans_active_o (freq_o),
		.op_target_o         (tgt_o),
		.float_error_pin_o   (pin_o)
	);

	// ==========================================================
	// Clock at 4 ns and a hang guard well above the test length
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			results();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk_i);
		req <= '{a, d, 1'b1, 1'b0};
	endtask

	// The expected word is noted when the read is issued
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge core_clk_i);
		req <= '{a, 64'h0, 1'b0, 1'b1};
		exp_q.push_back(e);
	endtask

	task automatic idle(input int n);
		@(posedge core_clk_i);
		req.wr <= 1'b0;
		req.rd <= 1'b0;
		repeat (n) @(posedge core_clk_i);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ==========================================================
	// Read data stands only in the cycle after the strobe, else zero
	always @(posedge core_clk_i) begin
		if (resetn_i) begin
			if (rd_seen)
				check(rd_data_o, exp_q.pop_front());
			else
				check(rd_data_o, 64'h0);
		end
		rd_seen <= req.rd;
	end

	// ==========================================================
	// Main sequence
	logic [ADDR_W-1:0] map[10];
	logic [DATA_W-1:0] d;
	logic [TGT_W-1:0]  t;
	logic              en3, sel, en13, hot, f, b;

	initial begin
		map = '{OFS_EVTSEL0, OFS_EVTSEL1, OFS_OPCTL, OFS_CLKMOD, OFS_THIRQ,
			OFS_THSTAT, OFS_OPSTAT, OFS_THERM2, OFS_FEAT, 16'h01A1};
		resetn_i = 1'b0;
		req = '0;
		therm_hot_i = 1'b0;
		fp_error_i = 1'b0;
		break_event_i = 1'b0;
		rd_seen = 1'b0;
		cyc = 0;
		n_mismatch = 0;
		check_count = 0;
		void'($urandom(32'h053E));
		repeat (10) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		// Reset contents; only the two availability flags read as one
		foreach (map[i])
			rd(map[i], (map[i] == OFS_FEAT) ? 64'h0880 : 64'h0);
		// Plain storage, back to back with its read
		for (int i = 0; i < 6; i++) begin
			d = {$urandom, $urandom};
			wr(map[i], d);
			rd(map[i], d);
		end
		// Read-only, reserved and unmapped places ignore writes
		wr(OFS_OPSTAT, '1);
		rd(OFS_OPSTAT, 64'h0);
		wr(16'h01A1, '1);
		rd(16'h01A1, 64'h0);
		wr(OFS_THERM2, '1);
		rd(OFS_THERM2, 64'h0000_0000_0001_FFFF);
		wr(OFS_FEAT, '1);
		rd(OFS_FEAT, 64'h0000_0000_0000_2C88);
		wr(OFS_FEAT, 64'h0);
		rd(OFS_FEAT, 64'h0000_0000_0000_0880);
		idle(2);
		// Every mix of enable, select, second enable and sensor level
		for (int i = 0; i < 16; i++) begin
			{hot, en13, sel, en3} = i[3:0];
			t = TGT_W'($urandom);
			wr(OFS_FEAT, (64'(en13) << 13) | (64'(en3) << 3));
			wr(OFS_THERM2, (64'(sel) << 16) | 64'(t));
			idle(0);
			therm_hot_i <= hot;
			idle(5);
			#1;
			check(64'(duty_o), 64'(en3 & ~sel & hot));
			check(64'(freq_o), 64'(en3 & sel & en13 & hot));
			check(64'(tgt_o), (en3 & sel & en13 & hot) ? 64'(t) : 64'h0);
			rd(OFS_OPSTAT, {48'h0, tgt_o});
		end
		therm_hot_i <= 1'b0;
		// Error pin follows the break event only while multiplexing is on
		for (int m = 0; m < 2; m++) begin
			wr(OFS_FEAT, 64'(m) << 10);
			idle(2);
			repeat (8) begin
				f = 1'($urandom);
				b = 1'($urandom);
				fp_error_i <= f;
				break_event_i <= b;
				@(posedge core_clk_i);
				#1;
				check(64'(pin_o), 64'(m ? b : f));
			end
		end
		idle(3);
		results();
	end

endmodule
